// ### core/dcff_pkg.sv
// Function
// - mode pin caught at reset selects fall-through
// - fall-through: first word shows after three edges
// - write enable low stores word each edge
// - standard: empty flag rises after first write
// - standard: almost-empty high at n plus one
// - standard: half flag low at D/2+1
// - wide port depth is configured capacity
// - both ports narrow: depth doubles
// - almost-full low at D minus m
// - standard: full flag low blocks writes
// - reads release full, then other flags
// - standard: almost-empty low at n words
// - standard: empty low, reads ignored when empty
// - standard: empty/full flags two stages each
// - fall-through: output-ready low after first write
// - fall-through: almost-empty high at n plus two
// - fall-through: half flag low at D/2+2
// - fall-through depth is memory plus one
// - fall-through: input-ready high blocks writes
// - fall-through: almost-empty low at n+1 words
// - output-ready three stages, input-ready two
package dcff_pkg;
    localparam int DATA_W = 18;
    localparam int NARROW_W = 9;
    localparam int PTR_W = 12;
    localparam int CNT_W = 13;
    localparam int CMP_W = 14;
    // smallest family member; larger members change these two, MEM_WORDS and the pointer and count widths
    localparam logic [CNT_W-1:0] CAP_WIDE = 13'h0800;
    localparam logic [CNT_W-1:0] CAP_NARROW = 13'h1000;
    localparam int MEM_WORDS = 4096;
    localparam logic [CNT_W-1:0] OFFSET_RESET = 13'h0007;
    localparam logic [1:0] FALL_EDGES = 2'h3;
    localparam logic [1:0] INIT_CYCLES = 2'h3;
    localparam int SYNC_W = 24;
endpackage : dcff_pkg

// ### core/dcff_sync.sv
`timescale 1ns/100ps
module dcff_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : dcff_sync

// ### core/dcff_core.sv
`timescale 1ns/100ps
module dcff_core
    import dcff_pkg::*;
(
    // clock and master reset
    input wire logic CLK,
    input wire logic RSTN,
    // write port
    input wire logic WRITE_CLK,
    input wire logic WRITE_ENABLE_N,
    input wire logic [DATA_W-1:0] DATA_IN,
    // read port
    input wire logic READ_CLK,
    input wire logic READ_ENABLE_N,
    output logic [DATA_W-1:0] DATA_OUT,
    // configuration
    input wire logic FALLTHROUGH_SELECT_SERIAL_IN,
    input wire logic NARROW_WIDTH_SELECT,
    output logic FALL_THROUGH_MODE,
    output logic CONFIG_READY,
    // offset registers
    input wire logic OFFSET_LOAD,
    input wire logic [CNT_W-1:0] OFFSET_EMPTY,
    input wire logic [CNT_W-1:0] OFFSET_FULL,
    // status flags
    output logic EMPTY_FLAG_N,
    output logic OUTPUT_READY_N,
    output logic FULL_FLAG_N,
    output logic INPUT_SPACE_N,
    output logic ALMOST_EMPTY_N,
    output logic ALMOST_FULL_N,
    output logic HALF_LEVEL_N
);
    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
                                                  input logic [CNT_W-1:0] cap);
        logic [CNT_W-1:0] nx;
        nx = {1'b0, p} + 13'h0001;
        ptr_step = (nx == cap) ? 12'h000 : nx[PTR_W-1:0];
    endfunction : ptr_step

    logic [SYNC_W-1:0] s_in;
    logic s_wclk, s_rclk, s_wen_n, s_ren_n, s_mode, s_narrow;
    logic [DATA_W-1:0] s_din;
    logic wclk_d, rclk_d;
    logic [1:0] init_cnt;
    logic cfg_ready, fall_through_mode, narrow;
    logic [CNT_W-1:0] n_off, m_off;
    logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
    logic [PTR_W-1:0] wr_ptr, rd_ptr;
    logic [CNT_W-1:0] mem_count;
    logic out_valid;
    logic [1:0] fall_cnt;
    logic ef_s1, ef_s2, ff_s1, ff_s2, ir_s1, ir_s2;

    dcff_sync #(.W(SYNC_W)) u_sync (
        .clk(CLK),
        .rst_n(RSTN),
        .d({WRITE_CLK, READ_CLK, WRITE_ENABLE_N, READ_ENABLE_N,
            FALLTHROUGH_SELECT_SERIAL_IN, NARROW_WIDTH_SELECT, DATA_IN}),
        .q(s_in)
    );
    assign {s_wclk, s_rclk, s_wen_n, s_ren_n, s_mode, s_narrow, s_din} = s_in;

    // decode of link edges and capacity
    wire wclk_rise = s_wclk & ~wclk_d;
    wire rclk_rise = s_rclk & ~rclk_d;
    wire [CNT_W-1:0] cap = narrow ? CAP_NARROW : CAP_WIDE;
    wire [CMP_W-1:0] depth = {1'b0, cap} + {13'h0000, fall_through_mode};
    wire [CMP_W-1:0] total = {1'b0, mem_count} + {13'h0000, out_valid};
    wire mem_full = (mem_count == cap);
    wire mem_empty = (mem_count == 13'h0000);
    // data lands on the edge, so the write is gated by the live count
    // the staged flags block writes as well, so no word lands while full or not-ready shows
    wire wr_ok = cfg_ready & wclk_rise & ~s_wen_n & ~mem_full & ff_s2 & ~ir_s2;
    wire rd_std = cfg_ready & ~fall_through_mode & rclk_rise & ~s_ren_n & ~mem_empty;
    wire fall_load = cfg_ready & fall_through_mode & rclk_rise & ~out_valid & ~mem_empty
                     & (fall_cnt == FALL_EDGES - 2'h1);
    wire fall_through_mode_pop = cfg_ready & fall_through_mode & rclk_rise & ~s_ren_n & out_valid;
    wire mem_pop = rd_std | fall_load | (fall_through_mode_pop & ~mem_empty);
    wire next_out_valid = fall_load | (out_valid & ~(fall_through_mode_pop & mem_empty));
    wire [CNT_W-1:0] next_count = mem_count + {12'h000, wr_ok} - {12'h000, mem_pop};

    // flag thresholds, one extra word counted in fall-through for the output register
    wire [CMP_W-1:0] ae_limit = {1'b0, n_off} + {13'h0000, fall_through_mode};
    wire [CMP_W-1:0] hf_limit = {2'b00, cap[CNT_W-1:1]} + 14'h0001
                                + {13'h0000, fall_through_mode};
    wire [CMP_W-1:0] af_limit = depth - {1'b0, m_off};
    wire ae_high = total > ae_limit;
    wire hf_low = total >= hf_limit;
    wire af_low = total >= af_limit;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            wclk_d <= s_wclk;
            rclk_d <= s_rclk;
        end
    end

    // mode pins are caught once the synchroniser has settled after release
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            init_cnt <= 2'h0;
            cfg_ready <= 1'b0;
            fall_through_mode <= 1'b0;
            narrow <= 1'b0;
        end else if (!cfg_ready) begin
            init_cnt <= init_cnt + 2'h1;
            if (init_cnt == INIT_CYCLES - 2'h1) begin
                cfg_ready <= 1'b1;
                fall_through_mode <= s_mode;
                narrow <= s_narrow;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            n_off <= OFFSET_RESET;
            m_off <= OFFSET_RESET;
        end else if (OFFSET_LOAD) begin
            n_off <= OFFSET_EMPTY;
            m_off <= OFFSET_FULL;
        end
    end

    // storage has no reset; contents are only read behind the count
    always_ff @(posedge CLK) begin
        if (wr_ok) begin
            mem[wr_ptr] <= narrow ? {{(DATA_W-NARROW_W){1'b0}}, s_din[NARROW_W-1:0]} : s_din;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_ptr <= 12'h000;
            rd_ptr <= 12'h000;
            mem_count <= 13'h0000;
            DATA_OUT <= 18'h00000;
        end else begin
            mem_count <= next_count;
            if (wr_ok) begin
                wr_ptr <= ptr_step(wr_ptr, cap);
            end
            if (mem_pop) begin
                rd_ptr <= ptr_step(rd_ptr, cap);
                DATA_OUT <= mem[rd_ptr];
            end
        end
    end

    // fall-through output register with its own three-edge delay
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            out_valid <= 1'b0;
            fall_cnt <= 2'h0;
            OUTPUT_READY_N <= 1'b1;
        end else begin
            out_valid <= next_out_valid;
            OUTPUT_READY_N <= ~(fall_through_mode & next_out_valid);
            if (out_valid || mem_empty || !fall_through_mode) begin
                fall_cnt <= 2'h0;
            end else if (rclk_rise) begin
                fall_cnt <= fall_cnt + 2'h1;
            end
        end
    end

    // empty stages step on read edges or every cycle in fall-through, full stages on write edges or every cycle before config
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ef_s1 <= 1'b0;
            ef_s2 <= 1'b0;
            ff_s1 <= 1'b1;
            ff_s2 <= 1'b1;
            ir_s1 <= 1'b0;
            ir_s2 <= 1'b0;
        end else begin
            if (rclk_rise || fall_through_mode) begin
                ef_s1 <= fall_through_mode | ~mem_empty;
                ef_s2 <= ef_s1;
            end
            if (wclk_rise || !cfg_ready) begin
                ff_s1 <= fall_through_mode | ~mem_full;
                ff_s2 <= ff_s1;
                ir_s1 <= fall_through_mode & (total == depth);
                ir_s2 <= ir_s1;
            end
        end
    end
    assign EMPTY_FLAG_N = ef_s2;
    assign FULL_FLAG_N = ff_s2;
    assign INPUT_SPACE_N = ir_s2;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ALMOST_EMPTY_N <= 1'b0;
            ALMOST_FULL_N <= 1'b1;
            HALF_LEVEL_N <= 1'b1;
        end else begin
            ALMOST_EMPTY_N <= ae_high;
            ALMOST_FULL_N <= ~af_low;
            HALF_LEVEL_N <= ~hf_low;
        end
    end
    assign FALL_THROUGH_MODE = fall_through_mode;
    assign CONFIG_READY = cfg_ready;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_mode_stable;
        cfg_ready |=> (cfg_ready && $stable(fall_through_mode) && $stable(narrow));
    endproperty
    a_mode_stable: assert property (p_mode_stable) else $error("mode changed after reset");

    property p_fall_three;
        $rose(out_valid) |-> ($past(fall_cnt) == 2'h2 && $past(rclk_rise) && fall_through_mode);
    endproperty
    a_fall_three: assert property (p_fall_three) else $error("word fell through early");

    property p_count_bound;
        cfg_ready |-> (mem_count <= cap && total <= depth);
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("count beyond depth");

    property p_ae_level;
        cfg_ready |=> (ALMOST_EMPTY_N == ($past(total) > ($past({1'b0, n_off}) + $past(fall_through_mode))));
    endproperty
    a_ae_level: assert property (p_ae_level) else $error("almost-empty threshold wrong");

    property p_hf_level;
        (cfg_ready && !fall_through_mode) |=> (HALF_LEVEL_N == ($past(total) < ({2'b00, cap[CNT_W-1:1]} + 14'h0001)));
    endproperty
    a_hf_level: assert property (p_hf_level) else $error("half flag threshold wrong");

    property p_af_level;
        cfg_ready |=> (ALMOST_FULL_N == ($past(total) < ($past(depth) - {1'b0, $past(m_off)})));
    endproperty
    a_af_level: assert property (p_af_level) else $error("almost-full threshold wrong");

    property p_read_ignored;
        (cfg_ready && !fall_through_mode && mem_empty && rclk_rise && !s_ren_n) |=> $stable(rd_ptr);
    endproperty
    a_read_ignored: assert property (p_read_ignored) else $error("read taken while empty");

    property p_ir_blocks;
        (fall_through_mode && INPUT_SPACE_N && !mem_pop) |=> (mem_count <= $past(mem_count));
    endproperty
    a_ir_blocks: assert property (p_ir_blocks) else $error("write taken while not ready");

    property p_ef_two_edges;
        (!fall_through_mode && cfg_ready && $rose(EMPTY_FLAG_N)) |-> ($past(ef_s1) && $past(rclk_rise));
    endproperty
    a_ef_two_edges: assert property (p_ef_two_edges) else $error("empty flag not staged");

    property p_fall_through_mode_full;
        // the empty chain needs two cycles to fill with ones once the mode is caught
        (fall_through_mode && $past(fall_through_mode, 2)) |-> (ff_s2 && ef_s2);
    endproperty
    a_fall_through_mode_full: assert property (p_fall_through_mode_full) else $error("standard flags active in fall-through");

    c_fall: cover property (fall_load);
    c_full: cover property (mem_full && !fall_through_mode);
    c_reload: cover property (fall_through_mode_pop && !mem_empty);
    c_wrap: cover property (wr_ok && wr_ptr == cap[PTR_W-1:0] - 12'h001);
endmodule : dcff_core

// ### tb/dcff_peer.sv
`timescale 1ns/100ps
module dcff_peer
    import dcff_pkg::*;
(
    // link clocks
    output logic WRITE_CLK,
    output logic READ_CLK,
    // writer
    output logic WRITE_ENABLE_N,
    output logic [DATA_W-1:0] DATA_IN,
    // reader
    output logic READ_ENABLE_N
);
    logic [DATA_W-1:0] exp_q[$];
    logic [11:0] idx;

    initial begin
        WRITE_CLK = 1'b0;
        READ_CLK = 1'b0;
        WRITE_ENABLE_N = 1'b1;
        READ_ENABLE_N = 1'b1;
        DATA_IN = 18'h00000;
        idx = 12'h000;
    end
    // free-running link clocks, phase unrelated to the system clock
    initial begin
        #7;
        forever #160 WRITE_CLK = ~WRITE_CLK;
    end
    initial begin
        #101;
        forever #160 READ_CLK = ~READ_CLK;
    end

    // enable stays low across a burst, one word per write-clock rise
    task automatic put(input int k, input bit keep);
        logic [DATA_W-1:0] w;
        for (int i = 0; i < k; i++) begin
            @(negedge WRITE_CLK);
            idx = idx + 12'h001;
            // bit 12 set so no word equals the reset value of the outputs
            w = {5'($urandom), 1'b1, idx};
            WRITE_ENABLE_N <= 1'b0;
            DATA_IN <= w;
            if (keep) begin
                exp_q.push_back(w);
            end
        end
        @(negedge WRITE_CLK);
        WRITE_ENABLE_N <= 1'b1;
        DATA_IN <= ~DATA_IN;
    endtask : put

    // every word is requested with enable low at a read-clock rise
    task automatic get(input int k);
        repeat (k) begin
            @(negedge READ_CLK);
            READ_ENABLE_N <= 1'b0;
        end
        @(negedge READ_CLK);
        READ_ENABLE_N <= 1'b1;
    endtask : get
endmodule : dcff_peer

// ### tb/dcff_core_test.sv
`timescale 1ns/100ps
module dcff_core_test
    import dcff_pkg::*;
;
    logic clk, rstn, wclk, rclk, wen_n, ren_n, ft_sel, ld, mode, nar;
    logic [DATA_W-1:0] want;
    logic ftm, cfg_rdy, ef_n, or_n, ff_n, ir_n, ae_n, af_n, hf_n;
    logic [DATA_W-1:0] din, dout, last;
    logic [CNT_W-1:0] n_off, m_off;
    int error_cnt, n_compared, cnt, dep, n, m;

    dcff_core uut (.CLK(clk), .RSTN(rstn), .WRITE_CLK(wclk), .WRITE_ENABLE_N(wen_n),
        .DATA_IN(din), .READ_CLK(rclk), .READ_ENABLE_N(ren_n), .DATA_OUT(dout),
        .FALLTHROUGH_SELECT_SERIAL_IN(ft_sel), .NARROW_WIDTH_SELECT(nar),
        .FALL_THROUGH_MODE(ftm), .CONFIG_READY(cfg_rdy), .OFFSET_LOAD(ld),
        .OFFSET_EMPTY(n_off), .OFFSET_FULL(m_off), .EMPTY_FLAG_N(ef_n),
        .OUTPUT_READY_N(or_n), .FULL_FLAG_N(ff_n), .INPUT_SPACE_N(ir_n),
        .ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_N(af_n), .HALF_LEVEL_N(hf_n));
    dcff_peer peer (.WRITE_CLK(wclk), .READ_CLK(rclk), .WRITE_ENABLE_N(wen_n),
        .DATA_IN(din), .READ_ENABLE_N(ren_n));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        n_compared++;
        if (seen !== want) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // any new word on the outputs must be the oldest one written
    always @(posedge clk) begin
        if (rstn && dout !== last) begin
            if (peer.exp_q.size() == 0) begin
                check(dout, ~dout);
            end else begin
                want = peer.exp_q.pop_front();
                if (nar) want[DATA_W-1:NARROW_W] = '0;
                check(dout, want);
            end
        end
        last <= dout;
    end

    // {empty, out-ready, full, in-ready, almost-empty, almost-full, half}
    function automatic logic [6:0] flags(input int c);
        if (mode) begin
            return {1'b1, c == 0, 1'b1, c == dep, c > n + 1, c < dep - m, c < dep / 2 + 2};
        end
        return {c != 0, 1'b1, c != dep, 1'b0, c > n, c < dep - m, c < dep / 2 + 1};
    endfunction : flags

    // long settle covers the two- and three-stage flag chains on slow link clocks
    task automatic go(input int target, input bit wr_extra);
        if (wr_extra) peer.put(1, 1'b0);
        if (target > cnt) peer.put(target - cnt, 1'b1);
        if (target < cnt) peer.get(cnt - target);
        if (target == 0 && cnt == 0) peer.get(1);
        cnt = target;
        repeat (48) @(posedge clk);
        check(18'({ef_n, or_n, ff_n, ir_n, ae_n, af_n, hf_n}), 18'(flags(cnt)));
    endtask : go

    task automatic run(input logic ft, input logic nw);
        int k, f, lo, half;
        int seq[$];
        @(posedge clk);
        mode = ft;
        f = ft ? 1 : 0;
        dep = (nw ? 4096 : 2048) + f;
        ft_sel <= ft;
        nar <= nw;
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        k = 0;
        while (cfg_rdy !== 1'b1 && k < 10) begin
            @(posedge clk);
            k++;
        end
        if (k == 10) begin
            error_cnt++;
            stop_test();
        end
        check(18'(ftm), 18'(ft));
        n = 2 + $urandom_range(0, 4);
        m = 3 + $urandom_range(0, 4);
        n_off <= 13'(n);
        m_off <= 13'(m);
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        repeat (8) @(posedge clk);
        cnt = 0;
        lo = n + f;
        half = dep / 2 + 1 + f;
        if (nw) begin
            // narrow ports: short pass over the low thresholds keeps the run brief
            seq = '{1, lo, lo + 1, 1, 0};
            foreach (seq[i]) go(seq[i], 1'b0);
        end else begin
            seq = '{1, lo, lo + 1, half - 1, half, dep - m - 1, dep - m, dep - 1, dep};
            foreach (seq[i]) go(seq[i], 1'b0);
            // write into a full store is dropped, then drain through every threshold
            go(dep, 1'b1);
            seq = '{dep - 1, dep - m, dep - m - 1, half, half - 1, lo + 1, lo, 1, 0, 0};
            foreach (seq[i]) go(seq[i], 1'b0);
        end
        check(18'(peer.exp_q.size()), 18'h00000);
    endtask : run

    initial begin
        rstn = 1'b0;
        ft_sel = 1'b0;
        ld = 1'b0;
        n_off = 13'h0007;
        m_off = 13'h0007;
        mode = 1'b0;
        nar = 1'b0;
        want = 18'h00000;
        last = 18'h00000;
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(32'h5148));
        run(1'b0, 1'b0);
        run(1'b1, 1'b0);
        run(1'b1, 1'b1);
        stop_test();
    end
endmodule : dcff_core_test
